// ==== hdl/acc_top.sv ====
// Conversion controller for an eight-input 10-bit converter with a Wishbone slave.
// What this block does
// - Standby halts any conversion and leaves the result register untouched.
// - Writing one to the start bit launches a conversion; zero does nothing.
// - The start bit reads one while converting and zero once finished.
// - With start-on-read set, each result read launches a new conversion.
// - The divider-enable bit gates the prescaler; zero stops the converter clock.
// - Prescaler value N divides the system clock by N plus one.
// - A three-bit channel field selects analog input zero to seven in order.
// - A conversion lasts five converter clock cycles.
// - Completion sets the end flag and loads the 10-bit result.
// - The result register is read-only, unsigned 10 bits in the low bits.
// - The control register resets to 0x3FC4.
// - Completion is offered as both an interrupt and a pollable flag.
`timescale 1ns/1ps
module acc_top (
    input  wire logic        clk_sys_i,
    input  wire logic        rstn_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [31:0] wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    output logic             irq_o,
    output logic             conv_start_o,
    output logic             conv_tick_o,
    output logic      [2:0]  analog_input_o,
    output logic             standby_o,
    input  wire logic [9:0]  result_i
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    acc_pkg::acc_ctrl_type  ctrl;
    acc_pkg::acc_ctrl_type  next_ctrl;
    acc_pkg::acc_state_type state;
    acc_pkg::acc_state_type next_state;
    acc_pkg::acc_core_type  core;
    acc_pkg::acc_core_type  next_core;

    logic [2:0]                   tick_cnt;
    logic [2:0]                   next_tick_cnt;
    logic [acc_pkg::RESULT_W-1:0] result;
    logic [acc_pkg::RESULT_W-1:0] next_result;
    logic [acc_pkg::RESULT_W-1:0] result_meta;
    logic [acc_pkg::RESULT_W-1:0] result_sync;
    logic [acc_pkg::IRQ_W-1:0]    irq_status;
    logic [acc_pkg::IRQ_W-1:0]    next_irq_status;
    logic [acc_pkg::IRQ_W-1:0]    irq_enable;
    logic [acc_pkg::IRQ_W-1:0]    next_irq_enable;
    logic                         ack;
    logic                         next_ack;
    logic [31:0]                  rdata;
    logic [31:0]                  next_rdata;
    logic                         irq;
    logic                         next_irq;

    logic req;
    logic hit_ctrl;
    logic hit_result;
    logic wr_ctrl;
    logic rd_result;
    logic launch;
    logic done;
    logic tick;
    logic stby_after;

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    assign req        = wb_cyc_i && wb_stb_i && !ack;
    assign hit_ctrl   = (wb_adr_i == acc_pkg::CTRL_ADDR);
    assign hit_result = (wb_adr_i == acc_pkg::RESULT_ADDR);
    assign wr_ctrl    = req && wb_we_i && hit_ctrl && wb_sel_i[0];
    assign rd_result  = req && !wb_we_i && hit_result;

    // A write that leaves standby and sets the start bit together still launches.
    assign stby_after = wr_ctrl ? wb_dat_i[acc_pkg::STBY_BIT] : ctrl.standby;

    assign launch = !stby_after &&
                    ((wr_ctrl && wb_dat_i[acc_pkg::START_BIT]) ||
                     (rd_result && ctrl.start_rd));

    // A standby write in the last tick cycle also stops the conversion from completing.
    assign done = (state == acc_pkg::ST_BUSY) && !stby_after && tick &&
                  (tick_cnt == 3'(acc_pkg::CONV_TICKS - 1));

    // ------------------------------------------------------------------
    // Prescaler
    // ------------------------------------------------------------------
    acc_prescaler #(
        .DIV_W (acc_pkg::DIVVAL_W)
    ) u_prescaler (
        .clk_sys_i       (clk_sys_i),
        .rstn_i          (rstn_i),
        .enable_i        (ctrl.div_en && !ctrl.standby),
        .restart_i       (launch),
        .divider_value_i (ctrl.div_val),
        .tick_o          (tick)
    );

    // ------------------------------------------------------------------
    // Result input synchroniser
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            result_meta <= acc_pkg::RESULT_RESET;
            result_sync <= acc_pkg::RESULT_RESET;
        end else begin
            result_meta <= result_i;
            result_sync <= result_meta;
        end
    end

    // ------------------------------------------------------------------
    // Control register and conversion sequencer
    // ------------------------------------------------------------------
    always_comb begin
        next_ctrl     = ctrl;
        next_state    = state;
        next_tick_cnt = tick_cnt;
        next_result   = result;
        if (wr_ctrl) begin
            next_ctrl.chan     = wb_dat_i[acc_pkg::CHAN_LSB +: acc_pkg::CHAN_W];
            next_ctrl.standby  = wb_dat_i[acc_pkg::STBY_BIT];
            next_ctrl.start_rd = wb_dat_i[acc_pkg::RDSTART_BIT];
            next_ctrl.div_val[1:0] = wb_dat_i[7:6];
        end
        if (req && wb_we_i && hit_ctrl && wb_sel_i[1]) begin
            next_ctrl.div_val[7:2] = wb_dat_i[13:8];
            next_ctrl.div_en       = wb_dat_i[acc_pkg::DIVEN_BIT];
        end
        case (state)
            acc_pkg::ST_IDLE: begin
                next_tick_cnt = '0;
            end
            acc_pkg::ST_BUSY: begin
                if (ctrl.standby) begin
                    next_state    = acc_pkg::ST_IDLE;
                    next_tick_cnt = '0;
                end else if (done) begin
                    next_state     = acc_pkg::ST_IDLE;
                    next_tick_cnt  = '0;
                    next_result    = result_sync;
                    next_ctrl.flag = 1'b1;
                end else if (tick) begin
                    next_tick_cnt = tick_cnt + 3'h1;
                end
            end
            default: begin
                next_state    = acc_pkg::ST_IDLE;
                next_tick_cnt = '0;
            end
        endcase
        if (launch) begin
            next_state     = acc_pkg::ST_BUSY;
            next_tick_cnt  = '0;
            next_ctrl.flag = 1'b0;
        end
        next_ctrl.busy = (next_state == acc_pkg::ST_BUSY);
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            ctrl     <= acc_pkg::acc_ctrl_type'(acc_pkg::CTRL_RESET);
            state    <= acc_pkg::ST_IDLE;
            tick_cnt <= '0;
            result   <= acc_pkg::RESULT_RESET;
        end else begin
            ctrl     <= next_ctrl;
            state    <= next_state;
            tick_cnt <= next_tick_cnt;
            result   <= next_result;
        end
    end

    // ------------------------------------------------------------------
    // Converter core signals
    // ------------------------------------------------------------------
    always_comb begin
        next_core.start   = launch;
        next_core.tick    = tick && (state == acc_pkg::ST_BUSY) && !stby_after;
        next_core.chan    = next_ctrl.chan;
        next_core.standby = next_ctrl.standby;
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            core <= '{start: 1'b0, tick: 1'b0, chan: '0, standby: 1'b1};
        end else begin
            core <= next_core;
        end
    end

    assign conv_start_o   = core.start;
    assign conv_tick_o    = core.tick;
    assign analog_input_o = core.chan;
    assign standby_o      = core.standby;

    // ------------------------------------------------------------------
    // Interrupt status, enable and clear
    // ------------------------------------------------------------------
    always_comb begin
        next_irq_status = irq_status;
        next_irq_enable = irq_enable;
        if (req && wb_we_i && wb_sel_i[0]) begin
            if (wb_adr_i == acc_pkg::IRQ_CLR_ADDR) begin
                next_irq_status = irq_status & ~wb_dat_i[acc_pkg::IRQ_W-1:0];
            end
            if (wb_adr_i == acc_pkg::IRQ_EN_ADDR) begin
                next_irq_enable = wb_dat_i[acc_pkg::IRQ_W-1:0];
            end
        end
        // A completion in the clearing cycle is kept.
        if (done) begin
            next_irq_status[acc_pkg::IRQ_DONE_BIT] = 1'b1;
        end
        next_irq = |(next_irq_status & next_irq_enable);
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            irq_status <= '0;
            irq_enable <= '0;
            irq        <= 1'b0;
        end else begin
            irq_status <= next_irq_status;
            irq_enable <= next_irq_enable;
            irq        <= next_irq;
        end
    end

    assign irq_o = irq;

    // ------------------------------------------------------------------
    // Read data and acknowledge
    // ------------------------------------------------------------------
    always_comb begin
        next_ack   = req;
        next_rdata = '0;
        if (req && !wb_we_i) begin
            case (wb_adr_i)
                acc_pkg::CTRL_ADDR: begin
                    next_rdata[acc_pkg::CTRL_W-1:0] = ctrl;
                end
                acc_pkg::RESULT_ADDR: begin
                    next_rdata[acc_pkg::RESULT_W-1:0] = result;
                end
                acc_pkg::IRQ_STAT_ADDR: begin
                    next_rdata[acc_pkg::IRQ_W-1:0] = irq_status;
                end
                acc_pkg::IRQ_EN_ADDR: begin
                    next_rdata[acc_pkg::IRQ_W-1:0] = irq_enable;
                end
                default: begin
                    next_rdata = '0;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            ack   <= 1'b0;
            rdata <= '0;
        end else begin
            ack   <= next_ack;
            rdata <= next_rdata;
        end
    end

    assign wb_ack_o = ack;
    assign wb_dat_o = rdata;

endmodule

// ==== hdl/acc_pkg.sv ====
// Package with register map, field layout and types of the converter controller.
package acc_pkg;

    // ------------------------------------------------------------------
    // Register addresses
    // ------------------------------------------------------------------
    localparam logic [31:0] CTRL_ADDR    = 32'h15800000;
    localparam logic [31:0] RESULT_ADDR  = 32'h15800004;
    localparam logic [31:0] IRQ_STAT_ADDR = 32'h15800008;
    localparam logic [31:0] IRQ_EN_ADDR  = 32'h1580000C;
    localparam logic [31:0] IRQ_CLR_ADDR = 32'h15800010;

    // ------------------------------------------------------------------
    // Control register layout and reset value
    // ------------------------------------------------------------------
    localparam int          CTRL_W      = 16;
    localparam logic [15:0] CTRL_RESET  = 16'h3FC4;
    localparam int          FLAG_BIT    = 15;
    localparam int          DIVEN_BIT   = 14;
    localparam int          DIVVAL_LSB  = 6;
    localparam int          DIVVAL_W    = 8;
    localparam int          CHAN_LSB    = 3;
    localparam int          CHAN_W      = 3;
    localparam int          STBY_BIT    = 2;
    localparam int          RDSTART_BIT = 1;
    localparam int          START_BIT   = 0;

    // ------------------------------------------------------------------
    // Result and conversion timing
    // ------------------------------------------------------------------
    localparam int          RESULT_W    = 10;
    localparam logic [9:0]  RESULT_RESET = 10'h000;
    localparam int          CONV_TICKS  = 5;
    localparam int          IRQ_DONE_BIT = 0;
    localparam int          IRQ_W       = 1;

    typedef struct packed {
        logic                flag;
        logic                div_en;
        logic [DIVVAL_W-1:0] div_val;
        logic [CHAN_W-1:0]   chan;
        logic                standby;
        logic                start_rd;
        logic                busy;
    } acc_ctrl_type;

    typedef struct packed {
        logic                start;
        logic                tick;
        logic [CHAN_W-1:0]   chan;
        logic                standby;
    } acc_core_type;

    typedef enum logic [0:0] {
        ST_IDLE,
        ST_BUSY
    } acc_state_type;

endpackage

// ==== hdl/acc_prescaler.sv ====
// Prescaler that turns the system clock into converter clock enable pulses.
`timescale 1ns/1ps
module acc_prescaler #(
    parameter int DIV_W = 8
) (
    input  wire logic             clk_sys_i,
    input  wire logic             rstn_i,
    input  wire logic             enable_i,
    input  wire logic             restart_i,
    input  wire logic [DIV_W-1:0] divider_value_i,
    output logic                  tick_o
);

    // ------------------------------------------------------------------
    // Divider counter
    // ------------------------------------------------------------------
    logic [DIV_W-1:0] count;
    logic [DIV_W-1:0] next_count;
    logic             tick;
    logic             next_tick;

    // One pulse every divider_value+1 cycles while enabled.
    always_comb begin
        next_count = count;
        next_tick  = 1'b0;
        if (restart_i || !enable_i) begin
            next_count = '0;
        end else if (count >= divider_value_i) begin
            next_count = '0;
            next_tick  = 1'b1;
        end else begin
            next_count = count + 1'b1;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            count <= '0;
            tick  <= 1'b0;
        end else begin
            count <= next_count;
            tick  <= next_tick;
        end
    end

    assign tick_o = tick;

endmodule

// ==== tb/acc_core_model.sv ====
// Behavioural analog core that answers each launch with a channel-coded sample.
`timescale 1ns/1ps
module acc_core_model (
    input  wire logic       clk_sys_i,
    input  wire logic       start_i,
    input  wire logic [2:0] chan_i,
    input  wire logic       standby_i,
    output logic      [9:0] result_o = 10'h2AA
);
    // Held sample is stable for the whole conversion, so the synchroniser settles.
    always @(posedge clk_sys_i) begin
        if (standby_i) begin
            result_o <= ~result_o;
        end else if (start_i) begin
            result_o <= {chan_i, 7'h35};
        end
    end
endmodule

// ==== tb/acc_top_chk.sv ====
// Checker of bus timing, channel, standby and tick behaviour at the controller ports.
`timescale 1ns/1ps
module acc_top_chk (
    input wire logic        clk_sys_i,
    input wire logic        rstn_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [31:0] wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        irq_o,
    input wire logic        conv_start_o,
    input wire logic        conv_tick_o,
    input wire logic [2:0]  analog_input_o,
    input wire logic        standby_o,
    input wire logic [9:0]  result_i
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rstn_i);
    logic [2:0] ticks;
    logic [2:0] next_ticks;
    logic       take_ctl;
    assign take_ctl = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_sel_i[0]
                      && wb_adr_i == acc_pkg::CTRL_ADDR;
    // Counts converter ticks since the last launch; five after reset and after a completed conversion.
    always_comb begin
        next_ticks = ticks;
        if (!rstn_i) begin
            next_ticks = 3'h5;
        end else if (conv_start_o) begin
            next_ticks = 3'h0;
        end else if (conv_tick_o) begin
            next_ticks = ticks + 3'h1;
        end
    end
    always_ff @(posedge clk_sys_i) begin
        ticks <= next_ticks;
    end
    ack_timing_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack missing one cycle after request");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
    dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("data without ack");
    result_width_a: assert property (wb_ack_o && !$past(wb_we_i)
        && $past(wb_adr_i) == acc_pkg::RESULT_ADDR |-> wb_dat_o[31:10] == 22'h0)
        else $error("result upper bits set");
    chan_follow_a: assert property (take_ctl |=> analog_input_o == $past(wb_dat_i[5:3]))
        else $error("channel select did not follow write");
    stby_follow_a: assert property (take_ctl |=> standby_o == $past(wb_dat_i[2]))
        else $error("standby did not follow write");
    stby_quiet_a: assert property (standby_o |-> !conv_start_o && !conv_tick_o)
        else $error("activity during standby");
    tick_limit_a: assert property (conv_tick_o && !conv_start_o |-> ticks < 3'h5)
        else $error("more than five ticks per conversion");
    cover property (conv_start_o);
    cover property (irq_o);
    cover property (conv_tick_o && ticks == 3'h4);
endmodule

bind acc_top acc_top_chk u_chk (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_o(irq_o),
    .conv_start_o(conv_start_o), .conv_tick_o(conv_tick_o), .analog_input_o(analog_input_o),
    .standby_o(standby_o), .result_i(result_i));

// ==== tb/test_adc_conversion_controller.sv ====
// Self-checking bench of the converter controller with its analog core model.
`timescale 1ns/1ps
`define CHK(g, e) check_val(32'(g), 32'(e))
module test_adc_conversion_controller;
    typedef struct packed {
        logic [31:0] adr;
        logic [31:0] wdat;
        logic [31:0] exp;
    } acc_row_type;
    logic        clk_sys_i = 1'b0;
    logic        rstn_i = 1'b0;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we = 1'b0;
    logic [31:0] adr = 32'h0;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic [31:0] q;
    logic        ack;
    logic        irq;
    logic        start;
    logic        tick;
    logic        stby;
    logic [2:0]  chan;
    logic [9:0]  result;
    int          num_errors = 0;
    int          total_checks = 0;
    int          launches = 0;
    int          ticks = 0;
    int          gap = 0;
    int          cyc_cnt = 0;
    int          last_tick = 0;
    int          n;
    acc_row_type rows [7] = '{
        '{acc_pkg::IRQ_EN_ADDR, 32'h1, 32'h1}, '{acc_pkg::IRQ_EN_ADDR, 32'h0, 32'h0},
        '{acc_pkg::IRQ_CLR_ADDR, 32'h1, 32'h0}, '{acc_pkg::IRQ_STAT_ADDR, 32'h1, 32'h0},
        '{acc_pkg::RESULT_ADDR, 32'h3FF, 32'h0}, '{32'h15800020, 32'hFFFF, 32'h0},
        '{acc_pkg::CTRL_ADDR, 32'h38, 32'h38}};
    acc_top DUT (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .irq_o(irq), .conv_start_o(start), .conv_tick_o(tick),
        .analog_input_o(chan), .standby_o(stby), .result_i(result));
    acc_core_model u_core (.clk_sys_i(clk_sys_i), .start_i(start), .chan_i(chan),
        .standby_i(stby), .result_o(result));
    initial begin
        forever #20 clk_sys_i = ~clk_sys_i;
    end
    // Counts launches and measures the spacing of converter ticks.
    always @(posedge clk_sys_i) begin
        cyc_cnt <= cyc_cnt + 1;
        if (start) begin
            launches <= launches + 1;
            ticks <= 0;
        end else if (tick) begin
            ticks <= ticks + 1;
            gap <= cyc_cnt - last_tick;
            last_tick <= cyc_cnt;
        end
    end
    task automatic check_val(input logic [31:0] g, input logic [31:0] e);
        total_checks++;
        if (g !== e) begin
            num_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk_sys_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge clk_sys_i);
            k++;
        end while (ack !== 1'b1 && k < 50);
        q = rdat;
        if (k >= 50) begin
            num_errors++;
            stop_test();
        end
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic wait_done();
        int k;
        k = 0;
        do begin
            bus(1'b0, acc_pkg::CTRL_ADDR, 32'h0);
            k++;
        end while (q[15] !== 1'b1 && k < 300);
    endtask
    function automatic logic [31:0] ctl(input logic [7:0] dv, input logic [2:0] ch,
                                        input logic [2:0] low);
        return {16'h0, 2'b01, dv, ch, low};
    endfunction
    task automatic settle(input int c);
        repeat (c) @(negedge clk_sys_i);
    endtask
    initial begin
        repeat (20) @(posedge clk_sys_i);
        rstn_i <= 1'b1;
        bus(1'b0, acc_pkg::CTRL_ADDR, 32'h0);
        `CHK(q, 32'h3FC4);
        bus(1'b0, acc_pkg::RESULT_ADDR, 32'h0);
        `CHK(q, 32'h0);
        $display("reset test done");
        foreach (rows[i]) begin
            bus(1'b1, rows[i].adr, rows[i].wdat);
            bus(1'b0, rows[i].adr, 32'h0);
            `CHK(q, rows[i].exp);
        end
        $display("register table test done");
        for (int ch = 0; ch < 8; ch++) begin
            bus(1'b1, acc_pkg::CTRL_ADDR, ctl(8'(9 + ch), 3'(ch), 3'h1));
            bus(1'b0, acc_pkg::CTRL_ADDR, 32'h0);
            `CHK(q, {2'b01, 8'(9 + ch), 3'(ch), 3'h1});
            wait_done();
            `CHK(q[0], 1'b0);
            `CHK(gap, 10 + ch);
            `CHK(ticks, 5);
            bus(1'b0, acc_pkg::RESULT_ADDR, 32'h0);
            `CHK(q, {3'(ch), 7'h35});
        end
        $display("channel test done");
        bus(1'b0, acc_pkg::IRQ_STAT_ADDR, 32'h0);
        `CHK(q, 32'h1);
        `CHK(irq, 1'b0);
        bus(1'b1, acc_pkg::IRQ_EN_ADDR, 32'h1);
        settle(2);
        `CHK(irq, 1'b1);
        bus(1'b1, acc_pkg::IRQ_CLR_ADDR, 32'h1);
        settle(2);
        `CHK(irq, 1'b0);
        $display("interrupt test done");
        n = launches;
        bus(1'b1, acc_pkg::CTRL_ADDR, ctl(8'd9, 3'h2, 3'h0));
        bus(1'b0, acc_pkg::CTRL_ADDR, 32'h0);
        settle(10);
        `CHK(launches, n);
        `CHK(q[15], 1'b1);
        bus(1'b1, acc_pkg::CTRL_ADDR, ctl(8'd9, 3'h5, 3'h2));
        bus(1'b0, acc_pkg::RESULT_ADDR, 32'h0);
        `CHK(q, {3'h7, 7'h35});
        settle(2);
        `CHK(launches, n + 1);
        wait_done();
        bus(1'b1, acc_pkg::CTRL_ADDR, ctl(8'd9, 3'h5, 3'h0));
        n = launches;
        bus(1'b0, acc_pkg::RESULT_ADDR, 32'h0);
        `CHK(q, {3'h5, 7'h35});
        settle(2);
        `CHK(launches, n);
        $display("start mode test done");
        bus(1'b1, acc_pkg::CTRL_ADDR, ctl(8'd20, 3'h3, 3'h1));
        settle(30);
        bus(1'b1, acc_pkg::CTRL_ADDR, ctl(8'd20, 3'h3, 3'h4));
        n = launches;
        bus(1'b1, acc_pkg::CTRL_ADDR, ctl(8'd20, 3'h3, 3'h5));
        settle(200);
        `CHK(launches, n);
        bus(1'b0, acc_pkg::RESULT_ADDR, 32'h0);
        `CHK(q, {3'h5, 7'h35});
        $display("standby test done");
        bus(1'b1, acc_pkg::CTRL_ADDR, ctl(8'd9, 3'h6, 3'h1) & 32'hBFFF);
        settle(100);
        `CHK(ticks, 0);
        bus(1'b1, acc_pkg::CTRL_ADDR, ctl(8'd9, 3'h6, 3'h0));
        wait_done();
        bus(1'b0, acc_pkg::RESULT_ADDR, 32'h0);
        `CHK(q, {3'h6, 7'h35});
        $display("divider enable test done");
        stop_test();
    end
    initial begin
        repeat (20000) @(posedge clk_sys_i);
        num_errors++;
        stop_test();
    end
endmodule
